/* File: rtl/stereo_glasses_sync.sv */
// stereo shutter-glasses sync: eye-select level and light-encoded pulse
// assumes vsync and frame eye come from pins; other inputs are on clk_in
//
// Functional notes
// - sync outputs only while 3D is active
// - eye-select high for left, low right
// - eye-select changes 1 ms before vsync
// - one light pulse per frame, shutters closed
// - tell illumination driver when to light
// - light off while shutters closed, except pulse; code gates this in link mode only
// - pulse colour red recommended, never blue
// - offset alternates B and B+D, B>500us
// - C always equals B plus D
// - pulse width A within 20 to 32 us
// - delta D within 128 to 163 us
// - 98 to 122 Hz frames, E over 2000us
`default_nettype none

module stereo_glasses_sync #(
    parameter int unsigned TOGGLE_CYC = 32'(stereo_sync_pkg::TOGGLE_CYC),
    parameter int unsigned OFFSET_B_CYC = 32'(stereo_sync_pkg::OFFSET_B_CYC),
    parameter int unsigned GAP_E_CYC = 32'(stereo_sync_pkg::GAP_E_CYC),
    parameter int unsigned A_MIN_CYC = 32'(stereo_sync_pkg::WIDTH_A_MIN_CYC),
    parameter int unsigned A_MAX_CYC = 32'(stereo_sync_pkg::WIDTH_A_MAX_CYC),
    parameter int unsigned D_MIN_CYC = 32'(stereo_sync_pkg::DELTA_D_MIN_CYC),
    parameter int unsigned D_MAX_CYC = 32'(stereo_sync_pkg::DELTA_D_MAX_CYC),
    parameter int unsigned PER_MIN_CYC = 32'(stereo_sync_pkg::PERIOD_MIN_CYC),
    parameter int unsigned PER_MAX_CYC = 32'(stereo_sync_pkg::PERIOD_MAX_CYC)
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic vsync_in,
    input wire logic frame_left_in,
    input wire logic enable_3d_in,
    input wire logic link_mode_in,
    input wire logic illum_req_in,
    input wire logic [1:0] color_sel_in,
    output logic eye_select_out,
    output logic light_on_out,
    output logic [1:0] pulse_color_out,
    output logic sync_active_out
);

    localparam int CW = stereo_sync_pkg::CNT_W;
    localparam int PW = stereo_sync_pkg::PW_W;
    localparam logic [CW-1:0] TOG = CW'(TOGGLE_CYC);
    localparam logic [CW-1:0] OFF_B = CW'(OFFSET_B_CYC);
    localparam logic [CW-1:0] GAP_E = CW'(GAP_E_CYC);
    localparam logic [CW-1:0] A_MIN = CW'(A_MIN_CYC);
    localparam logic [CW-1:0] A_MAX = CW'(A_MAX_CYC);
    localparam logic [CW-1:0] D_MIN = CW'(D_MIN_CYC);
    localparam logic [CW-1:0] D_MAX = CW'(D_MAX_CYC);
    localparam logic [CW-1:0] PER_MIN = CW'(PER_MIN_CYC);
    localparam logic [CW-1:0] PER_MAX = CW'(PER_MAX_CYC);
    localparam logic [CW-1:0] CNT_TOP = '1;

    typedef enum logic {ST_WAIT, ST_RUN} sync_state_t;

    logic [1:0] pin_s;
    logic vs_s;
    logic left_s;

    sync_two_ff #(
        .W(2)
    ) u_pin_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .d_in({vsync_in, frame_left_in}),
        .q_out(pin_s)
    );

    assign vs_s = pin_s[1];
    assign left_s = pin_s[0];

    sync_state_t st_q, st_d;
    logic vs_prev_q, vs_prev_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] per_q, per_d;
    logic eye_q, eye_d;
    logic closed_q, closed_d;
    logic pulse_q, pulse_d;
    logic done_q, done_d;
    logic alt_q, alt_d;
    logic [PW-1:0] pcnt_q, pcnt_d;
    logic light_q, light_d;
    logic gate_q, gate_d;
    logic [1:0] color_q, color_d;
    logic active_q, active_d;

    logic vs_rise;
    logic rate_ok;
    logic active;
    logic toggle_hit;
    logic [CW-1:0] a_cyc;
    logic [CW-1:0] d_cyc;
    logic [CW-1:0] c_cyc;
    logic [CW-1:0] start_pt;
    logic pulse_go;

    function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v,
                                            input logic [CW-1:0] lo,
                                            input logic [CW-1:0] hi);
        logic [CW-1:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction : clamp

    always_comb
    begin
        vs_rise = vs_s & ~vs_prev_q;
        rate_ok = (cnt_q >= PER_MIN) && (cnt_q <= PER_MAX);
        active = (st_q == ST_RUN) && enable_3d_in;
        // both figures track the frame period, as their nominal values do
        a_cyc = clamp((per_q >> 8) - (per_q >> 10), A_MIN, A_MAX);
        d_cyc = clamp(per_q >> 6, D_MIN, D_MAX);
        c_cyc = OFF_B + d_cyc;
        start_pt = per_q - (alt_q ? c_cyc : OFF_B);
        toggle_hit = active && (cnt_q == per_q - TOG);
        pulse_go = link_mode_in && active && closed_q && !done_q
                   && !pulse_q && (cnt_q == start_pt)
                   && (cnt_q >= GAP_E);
    end

    always_comb
    begin
        st_d = st_q;
        vs_prev_d = vs_s;
        cnt_d = (cnt_q == CNT_TOP) ? cnt_q : cnt_q + 1'h1;
        per_d = per_q;
        eye_d = eye_q;
        closed_d = closed_q;
        pulse_d = pulse_q;
        done_d = done_q;
        alt_d = alt_q;
        pcnt_d = pcnt_q;
        if (vs_rise)
        begin
            cnt_d = '0;
            per_d = cnt_q;
            st_d = (rate_ok && enable_3d_in) ? ST_RUN : ST_WAIT;
            closed_d = 1'h0;
            pulse_d = 1'h0;
            done_d = 1'h0;
        end
        else
        begin
            if (toggle_hit)
            begin
                // the coming frame shows the other eye
                eye_d = ~left_s;
                closed_d = 1'h1;
            end
            if (pulse_go)
            begin
                pulse_d = 1'h1;
                alt_d = ~alt_q;
                pcnt_d = PW'(1);
            end
            else if (pulse_q)
            begin
                if (CW'(pcnt_q) >= a_cyc)
                begin
                    pulse_d = 1'h0;
                    done_d = 1'h1;
                end
                else
                begin
                    pcnt_d = pcnt_q + 1'h1;
                end
            end
        end
        active_d = (st_d == ST_RUN) && enable_3d_in;
        // keyed to the next state, so a frame that drops out of range
        // clears the eye level on the same edge as sync_active_out
        if (!active_d)
        begin
            eye_d = stereo_sync_pkg::EYE_RIGHT;
            pulse_d = 1'h0;
            closed_d = 1'h0;
        end
        gate_d = link_mode_in && active_d && closed_d;
        // in link mode the closed-shutter window passes only the sync pulse; otherwise light follows illum_req_in
        light_d = gate_d ? pulse_d : illum_req_in;
        color_d = (color_sel_in == stereo_sync_pkg::COLOR_BLUE)
                  ? stereo_sync_pkg::COLOR_RED : color_sel_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_q <= ST_WAIT;
            vs_prev_q <= 1'h0;
            cnt_q <= '0;
            per_q <= '0;
            eye_q <= stereo_sync_pkg::EYE_RIGHT;
            closed_q <= 1'h0;
            pulse_q <= 1'h0;
            done_q <= 1'h0;
            alt_q <= 1'h0;
            pcnt_q <= '0;
            light_q <= 1'h0;
            gate_q <= 1'h0;
            color_q <= stereo_sync_pkg::COLOR_RED;
            active_q <= 1'h0;
        end
        else if (ce_in)
        begin
            st_q <= st_d;
            vs_prev_q <= vs_prev_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            eye_q <= eye_d;
            closed_q <= closed_d;
            pulse_q <= pulse_d;
            done_q <= done_d;
            alt_q <= alt_d;
            pcnt_q <= pcnt_d;
            light_q <= light_d;
            gate_q <= gate_d;
            color_q <= color_d;
            active_q <= active_d;
        end
    end

    assign eye_select_out = eye_q;
    assign light_on_out = light_q;
    assign pulse_color_out = color_q;
    assign sync_active_out = active_q;

    // checks; helper counts pulses within one frame
    logic [1:0] npulse_q;
    logic [CW-1:0] lead_q;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            npulse_q <= '0;
            lead_q <= '0;
        end
        else if (ce_in)
        begin
            if (vs_rise)
            begin
                npulse_q <= '0;
            end
            else if (pulse_go && npulse_q != 2'h3)
            begin
                npulse_q <= npulse_q + 1'h1;
            end
            if (toggle_hit)
            begin
                lead_q <= '0;
            end
            else if (lead_q != CNT_TOP)
            begin
                lead_q <= lead_q + 1'h1;
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in || !ce_in);

    sequence s_pulse_start;
        $rose(pulse_q) && !$past(vs_rise);
    endsequence

    a_eye_only_toggle: assert property (
        ($changed(eye_q) && active_q) |-> $past(toggle_hit))
        else $error("eye select moved away from the toggle point");

    a_eye_level: assert property (
        toggle_hit && !vs_rise |=> eye_q == ~$past(left_s))
        else $error("eye select level wrong for the coming frame");

    a_eye_lead: assert property (
        vs_rise && active && cnt_q == per_q |-> lead_q == TOG - 1'h1)
        else $error("eye select toggle not one lead time before vsync");

    a_one_pulse: assert property (
        vs_rise |-> npulse_q <= 2'h1)
        else $error("more than one light pulse in a frame");

    a_light_closed: assert property (
        (gate_q && !pulse_q) |-> !light_on_out)
        else $error("light on outside the pulse while shutters closed");

    a_pulse_light: assert property (
        s_pulse_start |-> light_on_out && closed_q)
        else $error("pulse not driven to the light source");

    a_pulse_offset: assert property (
        s_pulse_start |-> per_q - cnt_q + 1'h1
                          == ($past(alt_q) ? OFF_B + d_cyc : OFF_B))
        else $error("pulse offset does not alternate B and B plus D");

    a_pulse_width: assert property (
        $fell(pulse_q) && !$past(vs_rise) |->
            CW'($past(pcnt_q)) >= A_MIN && CW'($past(pcnt_q)) <= A_MAX)
        else $error("pulse width outside its window");

    a_delta_range: assert property (
        d_cyc >= D_MIN && d_cyc <= D_MAX)
        else $error("delta offset outside its window");

    a_rate_gap: assert property (
        pulse_go |-> cnt_q >= GAP_E && per_q >= PER_MIN && per_q <= PER_MAX)
        else $error("pulse outside supported rate or too early");

    a_no_blue: assert property (
        pulse_color_out != stereo_sync_pkg::COLOR_BLUE)
        else $error("blue selected for the sync pulse");

    a_idle_quiet: assert property (
        !active_q |-> !eye_q && !pulse_q)
        else $error("sync output while 3D inactive");

endmodule : stereo_glasses_sync

`default_nettype wire

/* File: rtl/stereo_sync_pkg.sv */
// constants for the stereo glasses sync block
// assumes a single 200 MHz clock; times are kept in microseconds
`default_nettype none

package stereo_sync_pkg;

    localparam longint unsigned CLK_PERIOD_PS = 5000;
    localparam longint unsigned PS_PER_US = 1000000;

    // frame counter width; covers the slowest supported frame plus margin
    localparam int CNT_W = 22;
    localparam int PW_W = 13;

    // eye-select lead ahead of the frame-start vsync edge
    localparam longint unsigned TOGGLE_LEAD_US = 1000;
    // least pulse offset before frame end, above the 500 us floor
    localparam longint unsigned OFFSET_B_US = 510;
    localparam longint unsigned OFFSET_B_FLOOR_US = 500;
    // least time from frame start to pulse, above the 2000 us floor
    localparam longint unsigned GAP_E_US = 2001;
    localparam longint unsigned WIDTH_A_MIN_US = 20;
    localparam longint unsigned WIDTH_A_MAX_US = 32;
    localparam longint unsigned DELTA_D_MIN_US = 128;
    localparam longint unsigned DELTA_D_MAX_US = 163;
    localparam longint unsigned RATE_MIN_HZ = 98;
    localparam longint unsigned RATE_MAX_HZ = 122;
    localparam longint unsigned PS_PER_S = 64'h0000_00E8_D4A5_1000;

    localparam longint unsigned TOGGLE_CYC =
        (TOGGLE_LEAD_US * PS_PER_US) / CLK_PERIOD_PS;
    localparam longint unsigned OFFSET_B_CYC =
        (OFFSET_B_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned GAP_E_CYC =
        (GAP_E_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned WIDTH_A_MIN_CYC =
        (WIDTH_A_MIN_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned WIDTH_A_MAX_CYC =
        (WIDTH_A_MAX_US * PS_PER_US) / CLK_PERIOD_PS;
    localparam longint unsigned DELTA_D_MIN_CYC =
        (DELTA_D_MIN_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned DELTA_D_MAX_CYC =
        (DELTA_D_MAX_US * PS_PER_US) / CLK_PERIOD_PS;
    // frame period window in cycles from the supported input rates
    localparam longint unsigned PERIOD_MIN_CYC =
        PS_PER_S / (RATE_MAX_HZ * CLK_PERIOD_PS);
    localparam longint unsigned PERIOD_MAX_CYC =
        (PS_PER_S + RATE_MIN_HZ * CLK_PERIOD_PS - 1)
        / (RATE_MIN_HZ * CLK_PERIOD_PS);

    // pulse colour codes towards the illumination driver
    localparam logic [1:0] COLOR_RED = 2'h0;
    localparam logic [1:0] COLOR_GREEN = 2'h1;
    localparam logic [1:0] COLOR_BLUE = 2'h2;

    localparam logic EYE_LEFT = 1'h1;
    localparam logic EYE_RIGHT = 1'h0;

endpackage : stereo_sync_pkg

`default_nettype wire

/* File: rtl/sync_two_ff.sv */
// two flip-flop synchroniser for pin-level inputs
// assumes inputs are levels slower than the clock; ce freezes it
`default_nettype none

module sync_two_ff #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb
    begin
        meta_d = ce_in ? d_in : meta_q;
        q_d = ce_in ? meta_q : q_out;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            q_out <= q_d;
        end
    end

endmodule : sync_two_ff

`default_nettype wire

/* File: bench/illum_driver_model.sv */
// stand-in for the ir emitter and the illumination driver; it only measures
// assumes light and eye-select are registered levels on the same clock
`default_nettype none

module illum_driver_model #(
    parameter int A_MAX = 8
) (
    input wire logic clk_in,
    input wire logic light_on_in,
    input wire logic eye_in,
    output int cyc,
    output int run_cnt,
    output int short_cnt,
    output int last_width,
    output int last_gap,
    output int rise_t,
    output int eye_chg,
    output int eye_t
);
    timeunit 1ns;
    timeprecision 100ps;
    int width;
    logic light_q;
    logic eye_q;

    // counters never reset: the bench only ever looks at differences
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        light_q <= light_on_in;
        eye_q <= eye_in;
        if (light_on_in === 1'h1 && light_q !== 1'h1)
        begin
            last_gap <= cyc - rise_t;
            rise_t <= cyc;
            width <= 1;
        end
        else if (light_on_in === 1'h1)
            width <= width + 1;
        if (light_on_in !== 1'h1 && light_q === 1'h1)
        begin
            run_cnt <= run_cnt + 1;
            last_width <= width;
            if (width <= A_MAX + 1)
                short_cnt <= short_cnt + 1;
        end
        if (eye_in !== eye_q)
        begin
            eye_chg <= eye_chg + 1;
            eye_t <= cyc;
        end
    end
endmodule : illum_driver_model

`default_nettype wire

/* File: bench/stereo_glasses_sync_test.sv */
// self-checking bench for the stereo glasses sync block, short timings
// assumes illum_driver_model; frame period 1200 cycles, so D=18 and A=4
`default_nettype none

module stereo_glasses_sync_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = 1200;
    localparam int TOG = 200;
    localparam int B = 60;
    localparam int D = 18;
    localparam int A = 4;
    localparam int GAP_E = 100;
    localparam int A_MIN = 4;
    localparam int A_MAX = 8;
    localparam int D_MIN = 8;
    localparam int D_MAX = 20;
    localparam int PER_MIN = 1000;
    localparam int PER_MAX = 1300;
    logic clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic ce_in = 1'h1;
    logic vsync_in = 1'h0;
    logic frame_left_in = 1'h0;
    logic enable_3d_in = 1'h0;
    logic link_mode_in = 1'h0;
    logic illum_req_in = 1'h0;
    logic [1:0] color_sel_in = 2'h0;
    logic eye_select_out, light_on_out, sync_active_out;
    logic [1:0] pulse_color_out;
    int cyc, run_cnt, short_cnt, last_width, last_gap, rise_t, eye_chg, eye_t;
    int vs_per = 0;
    int vcnt = 0;
    int mismatches = 0;
    int cmp_count = 0;

    always #2.5 clk_in = ~clk_in;

    // frame source: vsync pin high 8 cycles, eye of frame flips at each rise
    always @(posedge clk_in)
    begin
        vcnt <= (vs_per == 0 || vcnt >= vs_per - 1) ? 0 : vcnt + 1;
        #1;
        vsync_in = (vs_per != 0) && (vcnt < 8);
        if (vs_per != 0 && vcnt == 0)
            frame_left_in = ~frame_left_in;
    end

    stereo_glasses_sync #(.TOGGLE_CYC(TOG), .OFFSET_B_CYC(B),
        .GAP_E_CYC(GAP_E), .A_MIN_CYC(A_MIN), .A_MAX_CYC(A_MAX),
        .D_MIN_CYC(D_MIN), .D_MAX_CYC(D_MAX), .PER_MIN_CYC(PER_MIN),
        .PER_MAX_CYC(PER_MAX))
        u_stereo_glasses_sync (.clk_in(clk_in), .nrst_in(nrst_in),
        .ce_in(ce_in), .vsync_in(vsync_in), .frame_left_in(frame_left_in),
        .enable_3d_in(enable_3d_in), .link_mode_in(link_mode_in),
        .illum_req_in(illum_req_in), .color_sel_in(color_sel_in),
        .eye_select_out(eye_select_out), .light_on_out(light_on_out),
        .pulse_color_out(pulse_color_out),
        .sync_active_out(sync_active_out));

    illum_driver_model #(.A_MAX(A_MAX)) u_illum_driver_model (.clk_in(clk_in),
        .light_on_in(light_on_out), .eye_in(eye_select_out), .cyc(cyc),
        .run_cnt(run_cnt), .short_cnt(short_cnt), .last_width(last_width),
        .last_gap(last_gap), .rise_t(rise_t), .eye_chg(eye_chg),
        .eye_t(eye_t));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen,
                exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // returns just after the clock edge at which a vsync pin rise is driven
    task automatic to_frame(input int n);
        int k;
        repeat (n)
        begin
            k = 0;
            do
            begin
                @(posedge clk_in);
                #1;
                k++;
            end while (vcnt != 0 && k < 3000);
            if (k >= 3000)
            begin
                mismatches++;
                close_out();
            end
        end
    endtask : to_frame

    task automatic t_disabled();
        int s0;
        link_mode_in = 1'h1;
        s0 = short_cnt;
        to_frame(4);
        chk(sync_active_out, 1'h0);
        chk(eye_select_out, 1'h0);
        chk(short_cnt - s0, 0);
        $display("test disabled done");
    endtask : t_disabled

    task automatic t_ir_eye();
        int e0;
        int g;
        enable_3d_in = 1'h1;
        link_mode_in = 1'h0;
        to_frame(4);
        e0 = eye_chg;
        repeat (3)
        begin
            to_frame(1);
            #1;
            g = cyc - eye_t;
            chk(sync_active_out, 1'h1);
            chk(eye_select_out, frame_left_in);
            // pin synchroniser latency makes the lead a little uncertain
            chk(g >= TOG - 4 && g <= TOG + 2, 1'h1);
            chk(light_on_out, 1'h0);
        end
        chk(eye_chg - e0, 3);
        $display("test eye level done");
    endtask : t_ir_eye

    task automatic t_link();
        int s0;
        int g0;
        int d;
        to_frame(1);
        link_mode_in = 1'h1;
        to_frame(3);
        s0 = short_cnt;
        to_frame(1);
        g0 = last_gap;
        d = rise_t - eye_t;
        chk(d == TOG - B || d == TOG - B - D, 1'h1);
        chk(last_width, A);
        to_frame(1);
        chk(g0 + last_gap, 2 * P);
        chk(g0 - last_gap == 2 * D || last_gap - g0 == 2 * D, 1);
        chk(short_cnt - s0, 2);
        $display("test light pulses done");
    endtask : t_link

    task automatic t_gate();
        int r0;
        int s0;
        illum_req_in = 1'h1;
        to_frame(1);
        r0 = run_cnt;
        s0 = short_cnt;
        to_frame(2);
        chk(run_cnt - r0, 4);
        chk(short_cnt - s0, 2);
        illum_req_in = 1'h0;
        $display("test light gating done");
    endtask : t_gate

    task automatic t_colour();
        for (int i = 0; i < 4; i++)
        begin
            color_sel_in = i[1:0];
            to_frame(1);
            chk(pulse_color_out, (i == 2) ? 0 : i);
        end
        color_sel_in = 2'h0;
        $display("test colour done");
    endtask : t_colour

    task automatic t_period();
        vs_per = 900;
        to_frame(3);
        chk(sync_active_out, 1'h0);
        chk(eye_select_out, 1'h0);
        vs_per = 1300;
        to_frame(4);
        chk(sync_active_out, 1'h1);
        $display("test frame rate done");
    endtask : t_period

    // mid-frame freeze: nothing may move while the clock enable is low
    task automatic t_freeze();
        logic [1:0] c0;
        logic e0;
        to_frame(1);
        repeat (300) @(posedge clk_in);
        #1;
        c0 = pulse_color_out;
        e0 = eye_select_out;
        ce_in = 1'h0;
        color_sel_in = 2'h1;
        repeat (20) @(posedge clk_in);
        #1;
        chk(pulse_color_out, c0);
        chk(eye_select_out, e0);
        ce_in = 1'h1;
        @(posedge clk_in);
        #1;
        chk(pulse_color_out, 2'h1);
        color_sel_in = 2'h0;
        $display("test clock enable done");
    endtask : t_freeze

    task automatic t_mid_reset();
        repeat (1100) @(posedge clk_in);
        #1;
        nrst_in = 1'h0;
        #1;
        chk(light_on_out, 1'h0);
        chk(eye_select_out, 1'h0);
        chk(sync_active_out, 1'h0);
        @(posedge clk_in);
        #1;
        nrst_in = 1'h1;
        @(posedge clk_in);
        #1;
        chk(sync_active_out, 1'h0);
        chk(eye_select_out, 1'h0);
        to_frame(3);
        chk(sync_active_out, 1'h1);
        $display("test mid reset done");
    endtask : t_mid_reset

    initial
    begin
        repeat (6) @(posedge clk_in);
        #1;
        chk(eye_select_out, 1'h0);
        chk(light_on_out, 1'h0);
        chk(pulse_color_out, 2'h0);
        chk(sync_active_out, 1'h0);
        nrst_in = 1'h1;
        vs_per = P;
        t_disabled();
        t_ir_eye();
        t_link();
        t_gate();
        t_colour();
        t_period();
        t_freeze();
        t_mid_reset();
        close_out();
    end
endmodule : stereo_glasses_sync_test

`default_nettype wire
